// ### src/crc_top.sv
// Design decision made here: the Avalon-MM slave port.
module crc_top
	import crc_pkg::*;
(
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// avalon-mm slave
	input  wire logic [crc_pkg::CRC_ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic [31:0]                      avs_readdata,
	output logic                             avs_waitrequest,
	output logic [1:0]                       avs_response,
	// analog side
	input  wire logic [15:0]                 outputMv,
	input  wire logic                        feedsCoreSupply,
	input  wire logic                        brownoutEnabled,
	input  wire logic                        inputSupplyGood,
	output logic                             regulatorOn,
	output logic                             outputPinOe,
	output logic                             outputPinPulldown,
	output logic [3:0]                       outputLevelCode,
	output logic                             resetRequest,
	// interrupt
	output logic                             irq
);
	typedef struct packed
	{
		logic                 enable;
		logic                 highZ;
		logic [3:0]           level;
		logic                 latchedOff;
		logic                 resetReq;
		logic [CRC_IRQ_W-1:0] irqStat;
		logic [CRC_IRQ_W-1:0] irqMask;
		logic                 ack;
		logic [31:0]          rdata;
		logic [1:0]           resp;
	} crc_state_t;

	crc_state_t state_r;
	crc_state_t state_nxt;
	crc_ctl_if  ctlBus ();
	logic       access;
	logic       wrLo;
	logic       wrHi;
	logic       offNow;
	logic [CRC_IRQ_W-1:0] events;
	logic [3:0] newLevel;

	crc_reg_monitor u_monitor
	(
		.clk (clk),
		.rst (rst),
		.ctl (ctlBus.mon)
	);

	crc_reg_pin u_pin
	(
		.mode        (ctlBus.mode),
		.regOn       (regulatorOn),
		.pinDriveOe  (outputPinOe),
		.pinPulldown (outputPinPulldown)
	);

	assign ctlBus.enable    = state_r.enable & ~state_r.latchedOff;
	assign ctlBus.highZ     = state_r.highZ;
	assign ctlBus.levelCode = state_r.level;
	assign ctlBus.outputMv  = outputMv;

	always_comb
	begin
		access   = (avs_read | avs_write) & ~state_r.ack;
		wrLo     = avs_write & access & avs_byteenable[0];
		wrHi     = avs_write & access & avs_byteenable[1];
		newLevel = wrLo ? avs_writedata[CRC_LVL_HI:CRC_LVL_LO]
			: state_r.level;
		ctlBus.levelRaise = wrLo
			&& avs_address == CRC_OFF_CTRL
			&& newLevel > state_r.level;
		offNow = ctlBus.mode == CRC_MODE_OFF;
		events = '0;
		events[CRC_IRQ_GOOD_RISE] = ctlBus.goodRise;
		events[CRC_IRQ_GOOD_FALL] = ctlBus.goodFall;
		events[CRC_IRQ_RESET_REQ] = offNow & feedsCoreSupply
			& brownoutEnabled;
		events[CRC_IRQ_LATCHED] = offNow & feedsCoreSupply
			& ~brownoutEnabled & ~state_r.latchedOff;
	end

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.ack   = access;
		state_nxt.resp  = 2'h0;
		state_nxt.rdata = 32'h0;
		// reset request stays high while shut down feeding the core supply with brownout enabled, until the chip reset lands
		state_nxt.resetReq = events[CRC_IRQ_RESET_REQ];
		if (events[CRC_IRQ_LATCHED])
			state_nxt.latchedOff = 1'b1;
		else if (!inputSupplyGood)
			state_nxt.latchedOff = 1'b0;
		if (access && avs_read)
		begin
			case (avs_address)
				CRC_OFF_CTRL:
				begin
					state_nxt.rdata[CRC_BIT_EN]  = state_r.enable;
					state_nxt.rdata[CRC_BIT_HIZ] = state_r.highZ;
					state_nxt.rdata[CRC_LVL_HI:CRC_LVL_LO] = state_r.level;
					state_nxt.rdata[CRC_BIT_GOOD] = ctlBus.good;
				end
				CRC_OFF_IRQSTAT:
					state_nxt.rdata[CRC_IRQ_W-1:0] = state_r.irqStat;
				CRC_OFF_IRQMASK:
					state_nxt.rdata[CRC_IRQ_W-1:0] = state_r.irqMask;
				CRC_OFF_STATUS:
				begin
					state_nxt.rdata[CRC_ST_MODE_LO+2:CRC_ST_MODE_LO] =
						ctlBus.mode;
					state_nxt.rdata[CRC_ST_LATCHED] = state_r.latchedOff;
				end
				default:
					state_nxt.resp = 2'h2;
			endcase
		end
		if (access && avs_write)
		begin
			case (avs_address)
				CRC_OFF_CTRL:
				begin
					if (wrLo)
					begin
						state_nxt.enable = avs_writedata[CRC_BIT_EN];
						state_nxt.highZ  = avs_writedata[CRC_BIT_HIZ];
						state_nxt.level  = newLevel;
					end
				end
				CRC_OFF_IRQSTAT:
					if (wrLo)
						state_nxt.irqStat = state_r.irqStat
							& ~avs_writedata[CRC_IRQ_W-1:0];
				CRC_OFF_IRQMASK:
					if (wrLo)
						state_nxt.irqMask = avs_writedata[CRC_IRQ_W-1:0];
				default:
					state_nxt.resp = 2'h2;
			endcase
		end
		// new events win over a clear in the same cycle
		state_nxt.irqStat = state_nxt.irqStat | events;
		if (wrHi)
			state_nxt.rdata = state_nxt.rdata;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r            <= '0;
			state_r.enable     <= CRC_RST_EN;
			state_r.highZ      <= CRC_RST_HIZ;
			state_r.level      <= CRC_RST_LVL;
			state_r.latchedOff <= 1'b0;
		end
		else
			state_r <= state_nxt;
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~state_r.ack;
	assign avs_readdata    = state_r.rdata;
	assign avs_response    = state_r.resp;
	assign outputLevelCode = state_r.level;
	assign resetRequest    = state_r.resetReq;
	assign irq             = |(state_r.irqStat & state_r.irqMask);
endmodule : crc_top

// ### src/crc_pkg.sv
package crc_pkg;
	// register map, byte addresses relative to block base
	localparam logic [31:0] CRC_BASE_ADDR   = 32'h4006_4000;
	localparam logic [3:0]  CRC_OFF_CTRL    = 4'h0;
	localparam logic [3:0]  CRC_OFF_IRQSTAT = 4'h4;
	localparam logic [3:0]  CRC_OFF_IRQMASK = 4'h8;
	localparam logic [3:0]  CRC_OFF_STATUS  = 4'hc;
	localparam int          CRC_ADDR_W      = 4;
	// control register fields
	localparam int CRC_BIT_EN    = 0;
	localparam int CRC_BIT_HIZ   = 1;
	localparam int CRC_LVL_LO    = 4;
	localparam int CRC_LVL_HI    = 7;
	localparam int CRC_BIT_GOOD  = 12;
	localparam logic       CRC_RST_EN  = 1'h1;
	localparam logic       CRC_RST_HIZ = 1'h0;
	localparam logic [3:0] CRC_RST_LVL = 4'hb;
	localparam logic [3:0] CRC_LVL_MIN = 4'h5;
	// output level in mV: 800 up to code 5, then 50 per step
	localparam int CRC_MV_BASE = 800;
	localparam int CRC_MV_STEP = 50;
	// regulation thresholds in percent of the selected level
	localparam int CRC_PCT_ASSERT   = 90;
	localparam int CRC_PCT_DEASSERT = 87;
	// interrupt status bits
	localparam int CRC_IRQ_GOOD_RISE = 0;
	localparam int CRC_IRQ_GOOD_FALL = 1;
	localparam int CRC_IRQ_RESET_REQ = 2;
	localparam int CRC_IRQ_LATCHED   = 3;
	localparam int CRC_IRQ_W         = 4;
	// status register bits
	localparam int CRC_ST_MODE_LO = 0;
	localparam int CRC_ST_LATCHED = 4;

	typedef enum logic [2:0]
	{
		CRC_MODE_NORMAL = 3'b001,
		CRC_MODE_HIZ    = 3'b010,
		CRC_MODE_OFF    = 3'b100
	} crc_mode_t;
endpackage : crc_pkg

// ### src/crc_ctl_if.sv
interface crc_ctl_if;
	import crc_pkg::*;
	logic            enable;
	logic            highZ;
	logic [3:0]      levelCode;
	logic            levelRaise;
	crc_mode_t       mode;
	logic [15:0]     outputMv;
	logic            good;
	logic            goodRise;
	logic            goodFall;

	modport ctl
	(
		output enable,
		output highZ,
		output levelCode,
		output levelRaise,
		input  mode,
		input  good,
		input  goodRise,
		input  goodFall
	);
	modport mon
	(
		input  enable,
		input  highZ,
		input  levelCode,
		input  levelRaise,
		output mode,
		output good,
		output goodRise,
		output goodFall,
		input  outputMv
	);
endinterface : crc_ctl_if

// ### src/crc_reg_monitor.sv
module crc_reg_monitor
	import crc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control side
	crc_ctl_if.mon    ctl
);
	typedef struct packed
	{
		logic good;
		logic goodRise;
		logic goodFall;
	} crc_mon_t;

	crc_mon_t         state_r;
	crc_mon_t         state_nxt;
	logic [15:0]      targetMv;
	logic [23:0]      scaledOut;
	logic [23:0]      assertLvl;
	logic [23:0]      deassertLvl;

	always_comb
	begin
		if (ctl.levelCode <= CRC_LVL_MIN)
			targetMv = 16'(CRC_MV_BASE);
		else
			targetMv = 16'(CRC_MV_BASE + CRC_MV_STEP
				* (int'(ctl.levelCode) - int'(CRC_LVL_MIN)));
		scaledOut   = 24'(ctl.outputMv) * 24'd100;
		assertLvl   = 24'(targetMv) * 24'(CRC_PCT_ASSERT);
		deassertLvl = 24'(targetMv) * 24'(CRC_PCT_DEASSERT);
	end

	always_comb
	begin
		ctl.mode = CRC_MODE_NORMAL;
		if (!ctl.enable)
			ctl.mode = CRC_MODE_OFF;
		else if (ctl.highZ)
			ctl.mode = CRC_MODE_HIZ;
	end

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.goodRise = 1'b0;
		state_nxt.goodFall = 1'b0;
		if (ctl.mode != CRC_MODE_NORMAL)
			state_nxt.good = 1'b0;
		else if (ctl.levelRaise)
			state_nxt.good = 1'b0;
		else if (!state_r.good && scaledOut >= assertLvl)
			state_nxt.good = 1'b1;
		else if (state_r.good && scaledOut < deassertLvl)
			state_nxt.good = 1'b0;
		state_nxt.goodRise = state_nxt.good & ~state_r.good;
		state_nxt.goodFall = ~state_nxt.good & state_r.good;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign ctl.good     = state_r.good;
	assign ctl.goodRise = state_r.goodRise;
	assign ctl.goodFall = state_r.goodFall;
endmodule : crc_reg_monitor

// ### src/crc_reg_pin.sv
module crc_reg_pin
	import crc_pkg::*;
(
	// mode in
	input  crc_pkg::crc_mode_t mode,
	// pin control out
	output logic               regOn,
	output logic               pinDriveOe,
	output logic               pinPulldown
);
	always_comb
	begin
		regOn       = 1'b0;
		pinDriveOe  = 1'b0;
		pinPulldown = 1'b0;
		case (mode)
			CRC_MODE_NORMAL:
			begin
				regOn      = 1'b1;
				pinDriveOe = 1'b1;
			end
			CRC_MODE_HIZ:
			begin
				pinDriveOe = 1'b0;
			end
			CRC_MODE_OFF:
			begin
				pinPulldown = 1'b1;
			end
			default:
			begin
				pinPulldown = 1'b1;
			end
		endcase
	end
endmodule : crc_reg_pin

// ### dv/crc_top_asserts.sv
module crc_top_asserts
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// register bus
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	// regulator side
	input wire logic        feedsCoreSupply,
	input wire logic        brownoutEnabled,
	input wire logic        regulatorOn,
	input wire logic        outputPinOe,
	input wire logic        outputPinPulldown,
	input wire logic [3:0]  outputLevelCode,
	input wire logic        resetRequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic ctrlRead = avs_read && !avs_waitrequest && avs_address == 4'h0;

	a_reset_normal: assert property (
		$fell(rst) |-> regulatorOn && outputLevelCode == 4'hb)
		else $error("control not at reset defaults");
	a_on_drive: assert property (
		regulatorOn == outputPinOe)
		else $error("pin drive differs from regulator state");
	a_pin_excl: assert property (
		!(outputPinOe && outputPinPulldown))
		else $error("pin driven and pulled down together");
	a_wait_one: assert property (
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("waitrequest not one cycle");
	a_write_level: assert property (
		avs_write && !avs_waitrequest && avs_address == 4'h0
		&& avs_byteenable[0] |=> {24'h0, outputLevelCode, 4'h0}
		== ($past(avs_writedata) & 32'hf0))
		else $error("level code not taken from write");
	a_reset_req: assert property (
		outputPinPulldown && feedsCoreSupply && brownoutEnabled
		|-> ##[0:1] resetRequest)
		else $error("no reset request on shutdown");
	a_unmapped_resp: assert property (
		(avs_read || avs_write) && !avs_waitrequest
		&& avs_address[1:0] != 2'h0 |-> avs_response == 2'b10)
		else $error("unmapped access not refused");
	a_rsv_zero: assert property (
		ctrlRead |-> (avs_readdata & 32'hffffef0c) == 32'h0)
		else $error("reserved control bits not zero");
	a_good_hiz: assert property (
		ctrlRead && !outputPinOe && !outputPinPulldown |-> !avs_readdata[12])
		else $error("good flag set in high impedance");
endmodule : crc_top_asserts

bind crc_top crc_top_asserts u_chk (.clk(clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .feedsCoreSupply(feedsCoreSupply),
	.brownoutEnabled(brownoutEnabled), .regulatorOn(regulatorOn),
	.outputPinOe(outputPinOe), .outputPinPulldown(outputPinPulldown),
	.outputLevelCode(outputLevelCode), .resetRequest(resetRequest));

// ### dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, rd = 0, wr = 0, wq;
	logic [3:0]  adr = 0, lvl;
	logic [31:0] wd = 0, rdata, rdv;
	logic [1:0]  resp, rsp;
	logic [3:0]  be = 4'hf;
	logic [15:0] mv = 0;
	logic        feeds = 0, brownout_detector = 0, sup = 1;
	logic        on, oe, pd, rreq, irq;
	int          mismatches = 0, total_checks = 0;

	always #5 clk = ~clk;

	crc_top u_dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wq), .avs_response(resp),
		.outputMv(mv), .feedsCoreSupply(feeds), .brownoutEnabled(brownout_detector),
		.inputSupplyGood(sup), .regulatorOn(on), .outputPinOe(oe),
		.outputPinPulldown(pd), .outputLevelCode(lvl),
		.resetRequest(rreq), .irq(irq));

	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// request held until waitrequest is seen low, released after that edge
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		n = 0;
		@(posedge clk);
		while (wq !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (wq !== 1'b0)
		begin
			mismatches++;
			wrap_up();
		end
		else
		begin
			rdv = rdata;
			rsp = resp;
			rd <= 0;
			wr <= 0;
		end
	endtask : bus

	task rdc(input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk("readdata", rdv, e);
	endtask : rdc

	task pins(input logic [2:0] e);
		repeat (2) @(posedge clk);
		chk("on oe pulldown", {on, oe, pd}, e);
	endtask : pins

	task setmv(input logic [15:0] v);
		mv <= v;
		repeat (3) @(posedge clk);
	endtask : setmv

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 0;
		rdc(4'h0, 32'hb1);
		pins(3'b110);
		chk("level", lvl, 4'hb);
		setmv(16'd1000);
		rdc(4'h0, 32'h10b1);
		setmv(16'd960);
		rdc(4'h0, 32'h10b1);
		setmv(16'd950);
		rdc(4'h0, 32'hb1);
		setmv(16'd980);
		rdc(4'h0, 32'hb1);
		setmv(16'd1000);
		bus(1, 4'h0, 32'hc1);
		rdc(4'h0, 32'hc1);
		// interrupt on good rise: pending while masked, raised once unmasked
		bus(1, 4'h4, 32'hf);
		bus(1, 4'h0, 32'hb1);
		setmv(16'd1000);
		chk("irq", irq, 1'b0);
		bus(1, 4'h8, 32'h1);
		setmv(16'd1000);
		chk("irq", irq, 1'b1);
		rdc(4'h4, 32'h1);
		rdc(4'h8, 32'h1);
		bus(1, 4'h4, 32'h1);
		setmv(16'd1000);
		chk("irq", irq, 1'b0);
		setmv(16'd0);
		for (int i = 0; i < 16; i++)
		begin
			bus(1, 4'h0, {24'h0, i[3:0], 4'h1});
			chk("level", lvl, i[3:0]);
			rdc(4'h0, {24'h0, i[3:0], 4'h1});
		end
		// low codes share the bottom level, top code sits at the top level
		bus(1, 4'h0, 32'h31);
		setmv(16'd720);
		rdc(4'h0, 32'h1031);
		bus(1, 4'h0, 32'h61);
		setmv(16'd720);
		rdc(4'h0, 32'h61);
		bus(1, 4'h0, 32'hf1);
		setmv(16'd1169);
		rdc(4'h0, 32'hf1);
		setmv(16'd1170);
		rdc(4'h0, 32'h10f1);
		bus(1, 4'h0, 32'hb1);
		setmv(16'd1000);
		bus(1, 4'h0, 32'hb3);
		pins(3'b000);
		rdc(4'h0, 32'hb3);
		rdc(4'hc, 32'h2);
		bus(1, 4'h0, 32'hb0);
		pins(3'b001);
		bus(1, 4'h0, 32'hb2);
		pins(3'b001);
		bus(1, 4'h0, 32'hffffffff);
		rdc(4'h0, 32'hf3);
		bus(1, 4'h2, 32'h0);
		chk("response", rsp, 2'b10);
		rdc(4'h2, 32'h0);
		chk("response", rsp, 2'b10);
		rdc(4'h0, 32'hf3);
		// a write without the low byte lane leaves the control word alone
		be <= 4'he;
		bus(1, 4'h0, 32'h0);
		be <= 4'hf;
		rdc(4'h0, 32'hf3);
		bus(1, 4'h0, 32'hb1);
		setmv(16'd0);
		feeds <= 1;
		brownout_detector <= 1;
		bus(1, 4'h0, 32'hb0);
		repeat (2) @(posedge clk);
		chk("reset request", rreq, 1'b1);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		rdc(4'h0, 32'hb1);
		pins(3'b110);
		brownout_detector <= 0;
		bus(1, 4'h0, 32'hb0);
		bus(1, 4'h0, 32'hb1);
		pins(3'b001);
		rdc(4'hc, 32'h14);
		sup <= 0;
		@(posedge clk);
		sup <= 1;
		bus(1, 4'h0, 32'hb1);
		pins(3'b110);
		rdc(4'hc, 32'h1);
		wrap_up();
	end
endmodule : testbench
